// ### hdl/wkirq_pkg.sv
package wkirq_pkg;
	// ----------------------------------------------------------------
	// Bus and register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int LINES = 16;
	localparam logic [7:0] IDX_CTRL = 8'hF9;
	localparam logic [7:0] IDX_MASK_HI = 8'hFA;
	localparam logic [7:0] IDX_MASK_LO = 8'hFB;
	localparam logic [7:0] IDX_EDGE_HI = 8'hFC;
	localparam logic [7:0] IDX_EDGE_LO = 8'hFD;
	localparam logic [7:0] IDX_PEND_HI = 8'hFE;
	localparam logic [7:0] IDX_PEND_LO = 8'hFF;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_STOP = 2;
	localparam int CTRL_CSEL = 1;
	localparam int CTRL_WSEL = 0;
	// ----------------------------------------------------------------
	// Stop entry timing
	// ----------------------------------------------------------------
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] STOP_ENTRY_CYC = 4'h3;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} wkirq_apb_t;
	typedef enum {SEQ_IDLE, SEQ_ONE, SEQ_ZERO, SEQ_ARMED, SEQ_STOPPED} wkirq_seq_t;
endpackage

// ### hdl/wkirq_unit.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module wkirq_unit (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rstn,
	// Register bus.
	input wire wkirq_pkg::wkirq_apb_t apb,
	output logic [wkirq_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins.
	input wire logic [wkirq_pkg::LINES-1:0] wakeLine,
	input wire logic nmiPin,
	input wire logic extIrqPin,
	input wire logic stopPinN,
	// Core and clock unit.
	input wire logic cpuRegWrite,
	output logic sharedIrqReq,
	output logic wakeEvent,
	output logic stopModeReq,
	output logic stopWake
);
	localparam int L = wkirq_pkg::LINES;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	logic [L-1:0] lineS1_q, lineS2_q, lineS3_q;
	logic nmiS1_q, nmiS2_q, nmiS3_q;
	logic extS1_q, extS2_q, stpS1_q, stpS2_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lineS1_q <= '0;
			lineS2_q <= '0;
			lineS3_q <= '0;
			{nmiS1_q, nmiS2_q, nmiS3_q} <= 3'h0;
			{extS1_q, extS2_q} <= 2'h0;
			{stpS1_q, stpS2_q} <= 2'h3;
		end else begin
			lineS1_q <= wakeLine;
			lineS2_q <= lineS1_q;
			lineS3_q <= lineS2_q;
			{nmiS1_q, nmiS2_q, nmiS3_q} <= {nmiPin, nmiS1_q, nmiS2_q};
			{extS1_q, extS2_q} <= {extIrqPin, extS1_q};
			{stpS1_q, stpS2_q} <= {stopPinN, stpS1_q};
		end
	end

	wire nmiRise = nmiS2_q & ~nmiS3_q;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire [7:0] idx = apb.paddr[wkirq_pkg::ADDR_W-1:2];
	wire selCtrl = idx == wkirq_pkg::IDX_CTRL;
	wire selMaskHi = idx == wkirq_pkg::IDX_MASK_HI;
	wire selMaskLo = idx == wkirq_pkg::IDX_MASK_LO;
	wire selEdgeHi = idx == wkirq_pkg::IDX_EDGE_HI;
	wire selEdgeLo = idx == wkirq_pkg::IDX_EDGE_LO;
	wire selPendHi = idx == wkirq_pkg::IDX_PEND_HI;
	wire selPendLo = idx == wkirq_pkg::IDX_PEND_LO;
	wire hit = selCtrl | selMaskHi | selMaskLo | selEdgeHi | selEdgeLo | selPendHi | selPendLo;
	wire access = apb.psel & apb.penable;
	wire wrEn = access & apb.pwrite & hit;
	wire [7:0] wd = apb.pwdata[7:0];
	wire ctrlWr = wrEn & selCtrl;
	wire wdStop = wd[wkirq_pkg::CTRL_STOP];
	wire otherWr = (wrEn & ~selCtrl) | cpuRegWrite;

	assign pready = 1'b1;
	assign pslverr = access & ~hit;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [L-1:0] mask_q, edge_q, pend_q, pend_d;
	logic stop_q, stop_d, csel_q, wsel_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mask_q <= '0;
			edge_q <= '0;
			csel_q <= 1'b0;
			wsel_q <= 1'b0;
		end else begin
			if (wrEn & selMaskHi) mask_q[15:8] <= wd;
			if (wrEn & selMaskLo) mask_q[7:0] <= wd;
			if (wrEn & selEdgeHi) edge_q[15:8] <= wd;
			if (wrEn & selEdgeLo) edge_q[7:0] <= wd;
			if (ctrlWr) begin
				csel_q <= wd[wkirq_pkg::CTRL_CSEL];
				wsel_q <= wd[wkirq_pkg::CTRL_WSEL];
			end
		end
	end

	// ----------------------------------------------------------------
	// Edge detection and pending bits
	// ----------------------------------------------------------------
	wire [L-1:0] edgeWrBlk = {{8{wrEn & selEdgeHi}}, {8{wrEn & selEdgeLo}}};
	logic [L-1:0] hwSet;

	genvar g;
	generate
		for (g = 0; g < L; g++) begin : gLine
			wire rise = lineS2_q[g] & ~lineS3_q[g];
			wire fall = ~lineS2_q[g] & lineS3_q[g];
			assign hwSet[g] = (edge_q[g] ? rise : fall) & ~edgeWrBlk[g];
		end
	endgenerate

	// A hardware event in the same cycle as a software clear survives.
	wire [L-1:0] swPend = {(wrEn & selPendHi) ? wd : pend_q[15:8],
		(wrEn & selPendLo) ? wd : pend_q[7:0]};
	assign pend_d = swPend | hwSet;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) pend_q <= '0;
		else pend_q <= pend_d;
	end

	// ----------------------------------------------------------------
	// Request routing
	// ----------------------------------------------------------------
	wire [L-1:0] active = pend_q & mask_q;
	wire anyActive = |active;
	wire wakeAny = wsel_q & anyActive;
	wire chanReq = csel_q ? anyActive : extS2_q;
	wire entryOk = ~nmiS2_q & wsel_q & ~anyActive & (|mask_q);

	// ----------------------------------------------------------------
	// Stop sequence
	// ----------------------------------------------------------------
	wkirq_pkg::wkirq_seq_t st_q, st_d;
	logic [wkirq_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic wakeOut_d;

	always_comb begin
		st_d = st_q;
		stop_d = stop_q;
		cnt_d = cnt_q;
		wakeOut_d = 1'b0;
		case (st_q)
			wkirq_pkg::SEQ_IDLE: begin
				if (ctrlWr) begin
					stop_d = wdStop;
					if (wdStop) st_d = wkirq_pkg::SEQ_ONE;
				end
			end
			wkirq_pkg::SEQ_ONE: begin
				if (otherWr) begin
					st_d = wkirq_pkg::SEQ_IDLE;
					stop_d = 1'b0;
				end else if (ctrlWr) begin
					stop_d = wdStop;
					if (!wdStop) st_d = wkirq_pkg::SEQ_ZERO;
				end
			end
			wkirq_pkg::SEQ_ZERO: begin
				if (otherWr) begin
					st_d = wkirq_pkg::SEQ_IDLE;
				end else if (ctrlWr) begin
					st_d = wkirq_pkg::SEQ_IDLE;
					if (wdStop && entryOk) begin
						st_d = wkirq_pkg::SEQ_ARMED;
						stop_d = 1'b1;
						cnt_d = '0;
					end else if (wdStop) begin
						stop_d = nmiS2_q;
					end
				end
			end
			wkirq_pkg::SEQ_ARMED: begin
				// Entry takes several cycles; any mapped or CPU register write, or a line wake-up, in that window cancels it.
				if (otherWr | ctrlWr | wakeAny) begin
					st_d = wkirq_pkg::SEQ_IDLE;
					stop_d = 1'b0;
				end else if (cnt_q == wkirq_pkg::STOP_ENTRY_CYC - 4'h1) begin
					st_d = wkirq_pkg::SEQ_STOPPED;
				end else begin
					cnt_d = cnt_q + 4'h1;
				end
			end
			wkirq_pkg::SEQ_STOPPED: begin
				if (wakeAny) begin
					st_d = wkirq_pkg::SEQ_IDLE;
					stop_d = 1'b0;
					wakeOut_d = 1'b1;
				end else if (nmiRise) begin
					st_d = wkirq_pkg::SEQ_IDLE;
					wakeOut_d = 1'b1;
				end
			end
			default: begin
				st_d = wkirq_pkg::SEQ_IDLE;
				stop_d = 1'b0;
			end
		endcase
	end

	wire stopReq_d = (st_d == wkirq_pkg::SEQ_STOPPED) | ~stpS2_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= wkirq_pkg::SEQ_IDLE;
			stop_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			st_q <= st_d;
			stop_q <= stop_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic [7:0] rdByte;
	logic [wkirq_pkg::DATA_W-1:0] prdata_q;

	assign rdByte = selCtrl ? {5'h00, stop_q, csel_q, wsel_q} :
		selMaskHi ? mask_q[15:8] : selMaskLo ? mask_q[7:0] :
		selEdgeHi ? edge_q[15:8] : selEdgeLo ? edge_q[7:0] :
		selPendHi ? pend_q[15:8] : selPendLo ? pend_q[7:0] : wkirq_pkg::RST_BYTE;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prdata_q <= '0;
			sharedIrqReq <= 1'b0;
			wakeEvent <= 1'b0;
			stopModeReq <= 1'b0;
			stopWake <= 1'b0;
		end else begin
			if (apb.psel & ~apb.penable) prdata_q <= {24'h000000, rdByte};
			sharedIrqReq <= chanReq;
			wakeEvent <= wakeAny;
			stopModeReq <= stopReq_d;
			stopWake <= wakeOut_d;
		end
	end

	assign prdata = prdata_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_third;
		st_q == wkirq_pkg::SEQ_ZERO && ctrlWr && wdStop && !otherWr;
	endsequence
	sequence s_quiet3;
		(!otherWr && !ctrlWr && !wakeAny && stpS2_q)[*3];
	endsequence

	property p_first;
		st_q == wkirq_pkg::SEQ_IDLE && ctrlWr && wdStop |=> stop_q;
	endproperty
	a_first: assert property (p_first) else $error("stop bit not set by first write");

	property p_enter;
		s_third ##0 entryOk ##1 s_quiet3 |=> stopModeReq;
	endproperty
	a_enter: assert property (p_enter) else $error("stop not entered after sequence");

	property p_refuse;
		s_third ##0 !entryOk |=> (!stopModeReq || !$past(stpS2_q)) [*2];
	endproperty
	a_refuse: assert property (p_refuse) else $error("stop entered despite refusal");

	property p_refuse_clr;
		s_third ##0 !entryOk && !nmiS2_q |=> !stop_q && st_q == wkirq_pkg::SEQ_IDLE;
	endproperty
	a_refuse_clr: assert property (p_refuse_clr) else $error("stop bit left set");

	property p_nmi_refuse;
		s_third ##0 nmiS2_q |=> stop_q && st_q != wkirq_pkg::SEQ_ARMED;
	endproperty
	a_nmi_refuse: assert property (p_nmi_refuse) else $error("nmi refusal wrong");

	property p_wake_clr;
		st_q == wkirq_pkg::SEQ_STOPPED && wakeAny |=> !stop_q && stopWake;
	endproperty
	a_wake_clr: assert property (p_wake_clr) else $error("wake-up left stop bit");

	property p_nmi_wake;
		st_q == wkirq_pkg::SEQ_STOPPED && !wakeAny && nmiRise |=> stop_q && stopWake;
	endproperty
	a_nmi_wake: assert property (p_nmi_wake) else $error("nmi wake-up wrong");

	property p_pin;
		!stpS2_q |=> stopModeReq;
	endproperty
	a_pin: assert property (p_pin) else $error("stop pin ignored");

	property p_abort;
		st_q == wkirq_pkg::SEQ_ARMED && otherWr |=> !stop_q ##1 (!stopModeReq || !$past(stpS2_q));
	endproperty
	a_abort: assert property (p_abort) else $error("write did not abort stop");

	property p_chan_pin;
		!csel_q |=> sharedIrqReq == $past(extS2_q);
	endproperty
	a_chan_pin: assert property (p_chan_pin) else $error("channel not fed by pin");

	property p_chan_on;
		csel_q && |(pend_q & mask_q) |=> sharedIrqReq;
	endproperty
	a_chan_on: assert property (p_chan_on) else $error("channel request missing");

	property p_chan_off;
		csel_q && (pend_q & mask_q) == '0 |=> !sharedIrqReq;
	endproperty
	a_chan_off: assert property (p_chan_off) else $error("channel request spurious");

	property p_wake_on;
		wsel_q && |(pend_q & mask_q) |=> wakeEvent;
	endproperty
	a_wake_on: assert property (p_wake_on) else $error("wake event missing");

	property p_wake_off;
		!wsel_q || (pend_q & mask_q) == '0 |=> !wakeEvent;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake event spurious");

	property p_edge;
		lineS2_q[0] && !lineS3_q[0] && edge_q[0] && !edgeWrBlk[0] |=> pend_q[0];
	endproperty
	a_edge: assert property (p_edge) else $error("rising edge not pended");

	property p_edge_fall;
		!lineS2_q[1] && lineS3_q[1] && !edge_q[1] && !edgeWrBlk[1] |=> pend_q[1];
	endproperty
	a_edge_fall: assert property (p_edge_fall) else $error("falling edge not pended");

	property p_edge_lost;
		edgeWrBlk[0] && !pend_q[0] |=> !pend_q[0];
	endproperty
	a_edge_lost: assert property (p_edge_lost) else $error("edge pended during edge write");

	property p_cancel_wake;
		st_q == wkirq_pkg::SEQ_ARMED && wakeAny |=> st_q == wkirq_pkg::SEQ_IDLE && !stop_q;
	endproperty
	a_cancel_wake: assert property (p_cancel_wake) else $error("wake-up did not cancel entry");

	property p_stopped;
		st_q == wkirq_pkg::SEQ_STOPPED |-> stop_q && stopModeReq;
	endproperty
	a_stopped: assert property (p_stopped) else $error("stop state without stop bit");

endmodule // wkirq_unit

// ### sim/wkirq_far_model.sv
`timescale 1ns/1ns
module wkirq_far_model (
	// Clock.
	input wire logic mclk,
	// Pins toward the unit.
	output logic [wkirq_pkg::LINES-1:0] wakeLine,
	output logic nmiPin,
	output logic extIrqPin,
	output logic stopPinN
);
	initial begin
		wakeLine = '0;
		nmiPin = 1'b0;
		extIrqPin = 1'b0;
		stopPinN = 1'b1;
	end
	// Each line changes once, just after an edge, and then holds, so no glitch is made.
	task automatic line(input int n, input logic v);
		@(posedge mclk);
		wakeLine[n] <= v;
	endtask
	task automatic pins(input logic nmi, input logic ext, input logic stpN);
		@(posedge mclk);
		nmiPin <= nmi;
		extIrqPin <= ext;
		stopPinN <= stpN;
	endtask
endmodule // wkirq_far_model

// ### sim/wakeup_interrupt_unit_bench.sv
`timescale 1ns/1ns
module wakeup_interrupt_unit_bench;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic cpuRegWrite = 1'b0;
	wkirq_pkg::wkirq_apb_t apb = '0;
	logic [31:0] prdata;
	logic pready, pslverr, sharedIrqReq, wakeEvent, stopModeReq, stopWake, rerr;
	logic [15:0] wakeLine;
	logic nmiPin, extIrqPin, stopPinN;
	logic [31:0] rdat;
	int n_mismatch = 0;
	int num_checks = 0;
	int nWake = 0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) if (stopWake === 1'b1) nWake++;
	wkirq_unit DUT (.mclk(mclk), .rstn(rstn), .apb(apb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wakeLine(wakeLine), .nmiPin(nmiPin), .extIrqPin(extIrqPin),
		.stopPinN(stopPinN), .cpuRegWrite(cpuRegWrite), .sharedIrqReq(sharedIrqReq),
		.wakeEvent(wakeEvent), .stopModeReq(stopModeReq), .stopWake(stopWake));
	wkirq_far_model FAR (.mclk(mclk), .wakeLine(wakeLine), .nmiPin(nmiPin),
		.extIrqPin(extIrqPin), .stopPinN(stopPinN));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge mclk);
		apb.psel <= 1'b1;
		apb.pwrite <= wr;
		apb.paddr <= {idx, 2'b00};
		apb.pwdata <= {24'h000000, d};
		@(posedge mclk);
		apb.penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdat = prdata;
		rerr = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
		xfer(1'b0, idx, 8'h00);
		chk(nm, {24'h000000, e}, rdat);
	endtask
	task automatic stopSeq();
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h05);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h05);
		repeat (6) @(posedge mclk);
	endtask
	task automatic test_done();
		$display("mismatches %0d checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic tRegs();
		for (int i = 8'hF9; i <= 8'hFF; i++) rd(i[7:0], wkirq_pkg::RST_BYTE, "reset value");
		xfer(1'b1, 8'h10, 8'h5A);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		xfer(1'b1, wkirq_pkg::IDX_EDGE_HI, 8'hA5);
		rd(wkirq_pkg::IDX_EDGE_HI, 8'hA5, "edge high");
	endtask
	task automatic tEdges();
		xfer(1'b1, wkirq_pkg::IDX_EDGE_LO, 8'h01);
		xfer(1'b1, wkirq_pkg::IDX_MASK_LO, 8'h03);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
		FAR.line(0, 1'b1);
		FAR.line(1, 1'b1);
		repeat (8) @(posedge mclk);
		rd(wkirq_pkg::IDX_PEND_LO, 8'h01, "rising pending");
		chk("wake event", 32'h1, {31'h0, wakeEvent});
		chk("channel off", 32'h0, {31'h0, sharedIrqReq});
		FAR.line(1, 1'b0);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h03);
		repeat (8) @(posedge mclk);
		rd(wkirq_pkg::IDX_PEND_LO, 8'h03, "falling pending");
		chk("channel req", 32'h1, {31'h0, sharedIrqReq});
		xfer(1'b1, wkirq_pkg::IDX_PEND_LO, rdat[7:0] & 8'hFC);
		repeat (3) @(posedge mclk);
		chk("channel clear", 32'h0, {31'h0, sharedIrqReq});
		xfer(1'b1, wkirq_pkg::IDX_PEND_HI, 8'h80);
		rd(wkirq_pkg::IDX_PEND_HI, 8'h80, "soft pending");
		xfer(1'b1, wkirq_pkg::IDX_PEND_HI, 8'h00);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
		FAR.pins(1'b0, 1'b1, 1'b1);
		repeat (6) @(posedge mclk);
		chk("pin source", 32'h1, {31'h0, sharedIrqReq});
		FAR.pins(1'b0, 1'b0, 1'b1);
	endtask
	task automatic tStop();
		// Line 0 idles high here; its falling edge is not its trigger, so it can wake later.
		FAR.line(0, 1'b0);
		stopSeq();
		chk("stop req", 32'h1, {31'h0, stopModeReq});
		rd(wkirq_pkg::IDX_CTRL, 8'h05, "stop bit set");
		FAR.line(0, 1'b1);
		repeat (8) @(posedge mclk);
		chk("wake exit", 32'h0, {31'h0, stopModeReq});
		chk("exit pulse", 32'h1, nWake);
		rd(wkirq_pkg::IDX_CTRL, 8'h01, "stop bit wake");
		xfer(1'b1, wkirq_pkg::IDX_PEND_LO, 8'h00);
		stopSeq();
		FAR.pins(1'b1, 1'b0, 1'b1);
		repeat (8) @(posedge mclk);
		chk("nmi exit", 32'h0, {31'h0, stopModeReq});
		chk("nmi pulse", 32'h2, nWake);
		rd(wkirq_pkg::IDX_CTRL, 8'h05, "stop bit nmi");
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
		stopSeq();
		chk("nmi refusal", 32'h0, {31'h0, stopModeReq});
		rd(wkirq_pkg::IDX_CTRL, 8'h05, "stop bit nmi high");
		FAR.pins(1'b0, 1'b0, 1'b1);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
	endtask
	task automatic tRefuse();
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h05);
		@(posedge mclk);
		cpuRegWrite <= 1'b1;
		@(posedge mclk);
		cpuRegWrite <= 1'b0;
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h05);
		repeat (6) @(posedge mclk);
		chk("abort cpu", 32'h0, {31'h0, stopModeReq});
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
		xfer(1'b1, wkirq_pkg::IDX_EDGE_HI, 8'h00);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h05);
		repeat (6) @(posedge mclk);
		chk("abort apb", 32'h0, {31'h0, stopModeReq});
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h01);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h05);
		xfer(1'b1, wkirq_pkg::IDX_EDGE_HI, 8'h00);
		repeat (6) @(posedge mclk);
		chk("abort armed", 32'h0, {31'h0, stopModeReq});
		rd(wkirq_pkg::IDX_CTRL, 8'h01, "stop bit armed abort");
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h04);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h00);
		xfer(1'b1, wkirq_pkg::IDX_CTRL, 8'h04);
		repeat (6) @(posedge mclk);
		chk("no wake select", 32'h0, {31'h0, stopModeReq});
		xfer(1'b1, wkirq_pkg::IDX_MASK_LO, 8'h00);
		stopSeq();
		chk("no mask", 32'h0, {31'h0, stopModeReq});
		rd(wkirq_pkg::IDX_CTRL, 8'h01, "stop bit refused");
		FAR.pins(1'b0, 1'b0, 1'b0);
		repeat (5) @(posedge mclk);
		chk("stop pin", 32'h1, {31'h0, stopModeReq});
		FAR.pins(1'b0, 1'b0, 1'b1);
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		tRegs();
		tEdges();
		tStop();
		tRefuse();
		test_done();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		test_done();
	end
endmodule // wakeup_interrupt_unit_bench
